// [hw/mspcr_pkg.sv]
// package: address map, field layout and codes for the serial port config regs
package mspcr_pkg;
    // ------------------------------------------------------------
    // uart windows
    // ------------------------------------------------------------
    localparam int unsigned NUM_PORTS = 32'h8;
    localparam logic [11:0] WIN_STEP = 12'h200;
    localparam int unsigned WIN_BITS = 32'h9;
    localparam logic [11:0] PORT4_ALT_BASE = 12'he00;
    localparam logic [2:0] PORT4_ALT_IDX = 3'h3;
    // ------------------------------------------------------------
    // auxiliary region
    // ------------------------------------------------------------
    localparam logic [3:0] OFS_SEL_1_2 = 4'h4;
    localparam logic [3:0] OFS_SEL_3_4 = 4'h5;
    localparam logic [3:0] OFS_SEL_5_6 = 4'h6;
    localparam logic [3:0] OFS_SEL_7_8 = 4'h7;
    localparam logic [3:0] OFS_GPIO_IN = 4'h8;
    localparam logic [3:0] OFS_GPIO_DIR = 4'h9;
    localparam logic [3:0] OFS_TERM_OUT = 4'ha;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    // every line comes out of reset as an input
    localparam logic [7:0] OE_RST = 8'hff;
    localparam int unsigned NIB_LO = 32'h0;
    localparam int unsigned NIB_HI = 32'h4;
    // ------------------------------------------------------------
    // line modes
    // ------------------------------------------------------------
    localparam logic [3:0] IF_RS232 = 4'h0;
    localparam logic [3:0] IF_RS422 = 4'h1;
    localparam logic [3:0] IF_RS485_2W = 4'hf;
    localparam logic [3:0] IF_RS485_4W = 4'hb;
    typedef enum logic [3:0] {
        MSPCR_LM_232 = 4'h1,
        MSPCR_LM_422 = 4'h2,
        MSPCR_LM_485_2W = 4'h4,
        MSPCR_LM_485_4W = 4'h8
    } mspcr_mode_e;
    // ------------------------------------------------------------
    // baud reference
    // ------------------------------------------------------------
    localparam int unsigned REF_CLK_HZ = 32'he10000;
    localparam int unsigned BAUD_OVERSAMPLE = 32'h10;
    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic rd;
        logic wr;
        logic [3:0] addr;
        logic [7:0] wdata;
    } mspcr_aux_req_s;
    typedef struct packed {
        logic hit;
        logic [2:0] port;
        logic [8:0] offset;
    } mspcr_win_s;
endpackage : mspcr_pkg

// [hw/mspcr_regs.sv]
// aux register region, uart window decode and line mode control
//
// Functional notes
// R01 - each port owns a 512 byte window
// R02 - four-port layout puts port 4 at 0xe00
// R03 - sixteen byte auxiliary region controls lines
// R04 - four bit selects packed two per byte
// R05 - select codes map to line modes
// R06 - four-port alternate: port 4 at 0x7
// R07 - byte 0x8 reads sampled gpio levels
// R08 - direction bit zero makes line input
// R09 - direction bit one drives output register
// R10 - byte 0xa drives termination switch lines
// R11 - divisor equals reference over sixteen baud
// R12 - software prefers memory space uart access
// R13 - unassigned aux bytes read zero, ignore writes
`timescale 1ns/1ns
module mspcr_regs (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic four_port,
    input wire mspcr_pkg::mspcr_aux_req_s aux_req,
    output logic [7:0] aux_rdata,
    output logic aux_rvalid,
    input wire logic [11:0] uart_addr,
    output mspcr_pkg::mspcr_win_s uart_win,
    input wire logic [7:0] gpio_in,
    output logic [7:0] gpio_out,
    output logic [7:0] gpio_oe_n,
    output logic [31:0] port_iface,
    output mspcr_pkg::mspcr_mode_e [7:0] port_mode
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0] sel_byte [4];
    logic [7:0] next_sel_byte [4];
    logic [7:0] gpio_direction;
    logic [7:0] next_gpio_direction;
    logic [7:0] termination_output;
    logic [7:0] next_termination_output;
    logic [7:0] gin_s1, gin_s2, gin_s3, gpio_input_level;
    logic [7:0] next_gpio_input_level;
    logic [7:0] next_aux_rdata;
    logic next_aux_rvalid;
    mspcr_pkg::mspcr_win_s next_uart_win;
    logic [31:0] next_port_iface;
    mspcr_pkg::mspcr_mode_e [7:0] next_port_mode;
    logic [7:0] next_gpio_out, next_gpio_oe_n;
    logic four_q;

    // ------------------------------------------------------------
    // gpio input sampling
    // ------------------------------------------------------------
    // R07 sampled input level
    always_comb begin
        next_gpio_input_level = gpio_input_level;
        for (int i = 0; i < 8; i++) begin
            // a change counts once stages two and three agree
            if (gin_s2[i] == gin_s3[i]) begin
                next_gpio_input_level[i] = gin_s3[i];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            gin_s1 <= mspcr_pkg::ZERO_BYTE;
            gin_s2 <= mspcr_pkg::ZERO_BYTE;
            gin_s3 <= mspcr_pkg::ZERO_BYTE;
            gpio_input_level <= mspcr_pkg::ZERO_BYTE;
            four_q <= 1'b0;
        end else if (clk_en) begin
            gin_s1 <= gpio_in;
            gin_s2 <= gin_s1;
            gin_s3 <= gin_s2;
            gpio_input_level <= next_gpio_input_level;
            four_q <= four_port;
        end
    end

    // ------------------------------------------------------------
    // aux register access
    // ------------------------------------------------------------
    // R03 sixteen byte region
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            next_sel_byte[b] = sel_byte[b];
        end
        next_gpio_direction = gpio_direction;
        next_termination_output = termination_output;
        next_aux_rdata = aux_rdata;
        next_aux_rvalid = aux_req.rd;
        if (aux_req.wr) begin
            unique case (aux_req.addr)
                mspcr_pkg::OFS_SEL_1_2: next_sel_byte[0] = aux_req.wdata;
                mspcr_pkg::OFS_SEL_3_4: next_sel_byte[1] = aux_req.wdata;
                mspcr_pkg::OFS_SEL_5_6: next_sel_byte[2] = aux_req.wdata;
                mspcr_pkg::OFS_SEL_7_8: next_sel_byte[3] = aux_req.wdata;
                // R08 direction register write
                mspcr_pkg::OFS_GPIO_DIR: next_gpio_direction = aux_req.wdata;
                // R10 termination output write
                mspcr_pkg::OFS_TERM_OUT:
                    next_termination_output = aux_req.wdata;
                // R13 other writes ignored
                default: ;
            endcase
        end
        if (aux_req.rd) begin
            unique case (aux_req.addr)
                mspcr_pkg::OFS_SEL_1_2: next_aux_rdata = sel_byte[0];
                mspcr_pkg::OFS_SEL_3_4: next_aux_rdata = sel_byte[1];
                mspcr_pkg::OFS_SEL_5_6: next_aux_rdata = sel_byte[2];
                mspcr_pkg::OFS_SEL_7_8: next_aux_rdata = sel_byte[3];
                mspcr_pkg::OFS_GPIO_IN: next_aux_rdata = gpio_input_level;
                mspcr_pkg::OFS_GPIO_DIR: next_aux_rdata = gpio_direction;
                mspcr_pkg::OFS_TERM_OUT: next_aux_rdata = termination_output;
                // R13 unassigned bytes read zero
                default: next_aux_rdata = mspcr_pkg::ZERO_BYTE;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            for (int b = 0; b < 4; b++) begin
                sel_byte[b] <= mspcr_pkg::RST_BYTE;
            end
            gpio_direction <= mspcr_pkg::RST_BYTE;
            termination_output <= mspcr_pkg::RST_BYTE;
            aux_rdata <= mspcr_pkg::ZERO_BYTE;
            aux_rvalid <= 1'b0;
        end else if (clk_en) begin
            for (int b = 0; b < 4; b++) begin
                sel_byte[b] <= next_sel_byte[b];
            end
            gpio_direction <= next_gpio_direction;
            termination_output <= next_termination_output;
            aux_rdata <= next_aux_rdata;
            aux_rvalid <= next_aux_rvalid;
        end
    end

    // ------------------------------------------------------------
    // line mode decode and gpio drive
    // ------------------------------------------------------------
    always_comb begin
        next_port_iface = '0;
        // R04 two nibbles per byte, odd port low
        for (int p = 0; p < 8; p++) begin
            next_port_iface[p*4 +: 4] = sel_byte[p/2][(p%2)*4 +: 4];
        end
        // R06 alternate layout: port 4 from 0x7 low nibble
        if (four_q) begin
            next_port_iface = '0;
            next_port_iface[3:0] = sel_byte[0][3:0];
            next_port_iface[7:4] = sel_byte[0][7:4];
            next_port_iface[11:8] = sel_byte[1][3:0];
            next_port_iface[15:12] = sel_byte[3][3:0];
        end
        // R05 select codes to line mode; unknown codes fall back to 232
        for (int p = 0; p < 8; p++) begin
            unique case (next_port_iface[p*4 +: 4])
                mspcr_pkg::IF_RS422: next_port_mode[p] = mspcr_pkg::MSPCR_LM_422;
                mspcr_pkg::IF_RS485_2W:
                    next_port_mode[p] = mspcr_pkg::MSPCR_LM_485_2W;
                mspcr_pkg::IF_RS485_4W:
                    next_port_mode[p] = mspcr_pkg::MSPCR_LM_485_4W;
                default: next_port_mode[p] = mspcr_pkg::MSPCR_LM_232;
            endcase
        end
        // R09 output lines follow the output register
        next_gpio_out = termination_output;
        next_gpio_oe_n = ~gpio_direction;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            port_iface <= '0;
            for (int p = 0; p < 8; p++) begin
                port_mode[p] <= mspcr_pkg::MSPCR_LM_232;
            end
            gpio_out <= mspcr_pkg::ZERO_BYTE;
            gpio_oe_n <= mspcr_pkg::OE_RST;
        end else if (clk_en) begin
            port_iface <= next_port_iface;
            port_mode <= next_port_mode;
            gpio_out <= next_gpio_out;
            gpio_oe_n <= next_gpio_oe_n;
        end
    end

    // ------------------------------------------------------------
    // uart window decode
    // ------------------------------------------------------------
    // R01 R02 window decode; R11 divisor lives inside each uart
    always_comb begin
        logic [2:0] idx;
        idx = uart_addr[11:9];
        next_uart_win.offset = uart_addr[8:0];
        next_uart_win.port = idx;
        next_uart_win.hit = 1'b1;
        if (four_q) begin
            // port 4 moved to step seven; steps 3..6 are holes
            next_uart_win.hit = (idx < mspcr_pkg::PORT4_ALT_IDX) ||
                (uart_addr[11:9] == mspcr_pkg::PORT4_ALT_BASE[11:9]);
            if (uart_addr[11:9] == mspcr_pkg::PORT4_ALT_BASE[11:9]) begin
                next_uart_win.port = mspcr_pkg::PORT4_ALT_IDX;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            uart_win <= '0;
        end else if (clk_en) begin
            uart_win <= next_uart_win;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_unmapped_zero: assert property ( // R13
        @(posedge ref_clk) disable iff (!rst_n)
        clk_en && aux_req.rd && aux_req.addr < mspcr_pkg::OFS_SEL_1_2
        |=> aux_rdata == mspcr_pkg::ZERO_BYTE)
        else $error("unmapped byte not zero");
    a_high_zero: assert property ( // R13
        @(posedge ref_clk) disable iff (!rst_n)
        clk_en && aux_req.rd && aux_req.addr > mspcr_pkg::OFS_TERM_OUT
        |=> aux_rdata == mspcr_pkg::ZERO_BYTE)
        else $error("upper unmapped byte not zero");
    a_write_ignored: assert property ( // R13
        @(posedge ref_clk) disable iff (!rst_n)
        clk_en && aux_req.wr && (aux_req.addr < mspcr_pkg::OFS_SEL_1_2 ||
        aux_req.addr == mspcr_pkg::OFS_GPIO_IN ||
        aux_req.addr > mspcr_pkg::OFS_TERM_OUT)
        |=> $stable(gpio_direction) && $stable(termination_output))
        else $error("unmapped write took effect");
    a_rvalid_pulse: assert property ( // R03
        @(posedge ref_clk) disable iff (!rst_n)
        clk_en |=> aux_rvalid == $past(aux_req.rd))
        else $error("read valid not one cycle after read");
    a_read_dir: assert property ( // R08
        @(posedge ref_clk) disable iff (!rst_n)
        clk_en && aux_req.rd && aux_req.addr == mspcr_pkg::OFS_GPIO_DIR
        |=> aux_rdata == $past(gpio_direction))
        else $error("direction read wrong");
    a_dir_write: assert property ( // R08
        @(posedge ref_clk) disable iff (!rst_n)
        clk_en && aux_req.wr && aux_req.addr == mspcr_pkg::OFS_GPIO_DIR
        ##1 clk_en |=> gpio_oe_n == ~$past(aux_req.wdata, 2))
        else $error("direction write not applied");
    a_oe_follow: assert property ( // R09
        @(posedge ref_clk) disable iff (!rst_n)
        clk_en |=> gpio_oe_n == ~$past(gpio_direction))
        else $error("output enable not from direction");
    a_term_drive: assert property ( // R10
        @(posedge ref_clk) disable iff (!rst_n)
        clk_en && aux_req.wr && aux_req.addr == mspcr_pkg::OFS_TERM_OUT
        ##1 clk_en |=> gpio_out == $past(aux_req.wdata, 2))
        else $error("termination not driven");
    a_out_follow: assert property ( // R09
        @(posedge ref_clk) disable iff (!rst_n)
        clk_en |=> gpio_out == $past(termination_output))
        else $error("output lines not from output register");
    a_win_port: assert property ( // R01
        @(posedge ref_clk) disable iff (!rst_n)
        clk_en && !four_q && uart_addr == 12'h400 |=>
        uart_win.port == 3'h2 && uart_win.offset == 9'h000)
        else $error("window step wrong");
    a_win_offset: assert property ( // R01
        @(posedge ref_clk) disable iff (!rst_n)
        clk_en |=> uart_win.offset == $past(uart_addr[8:0]))
        else $error("window offset wrong");
    a_port4_alt: assert property ( // R02
        @(posedge ref_clk) disable iff (!rst_n)
        clk_en && four_q && uart_addr[11:9] == 3'h7 |=>
        uart_win.hit && uart_win.port == 3'h3)
        else $error("port four window wrong");
    a_hole_miss: assert property ( // R02
        @(posedge ref_clk) disable iff (!rst_n)
        clk_en && four_q && uart_addr[11:9] == 3'h3 |=> !uart_win.hit)
        else $error("hole decoded");
    a_sel_nibble: assert property ( // R04
        @(posedge ref_clk) disable iff (!rst_n)
        clk_en && !four_q && aux_req.wr &&
        aux_req.addr == mspcr_pkg::OFS_SEL_3_4 ##1 clk_en && !four_q
        |=> port_iface[15:12] == $past(aux_req.wdata[7:4], 2))
        else $error("port four nibble wrong");
    a_alt_upper: assert property ( // R06
        @(posedge ref_clk) disable iff (!rst_n)
        clk_en && four_q |=> port_iface[31:16] == '0)
        else $error("unused ports not cleared in four-port layout");
    a_mode_422: assert property ( // R05
        @(posedge ref_clk) disable iff (!rst_n)
        port_iface[7:4] == mspcr_pkg::IF_RS422
        |-> port_mode[1] == mspcr_pkg::MSPCR_LM_422)
        else $error("rs-422 mode decode wrong");
    a_mode_485: assert property ( // R05
        @(posedge ref_clk) disable iff (!rst_n)
        port_iface[3:0] == mspcr_pkg::IF_RS485_2W
        |-> port_mode[0] == mspcr_pkg::MSPCR_LM_485_2W)
        else $error("mode decode wrong");
    a_mode_4w: assert property ( // R05
        @(posedge ref_clk) disable iff (!rst_n)
        port_iface[15:12] == mspcr_pkg::IF_RS485_4W
        |-> port_mode[3] == mspcr_pkg::MSPCR_LM_485_4W)
        else $error("four-wire mode decode wrong");
    a_input_read: assert property ( // R07
        @(posedge ref_clk) disable iff (!rst_n)
        clk_en && aux_req.rd && aux_req.addr == mspcr_pkg::OFS_GPIO_IN
        |=> aux_rdata == $past(gpio_input_level))
        else $error("input level read wrong");
    a_input_agree: assert property ( // R07
        @(posedge ref_clk) disable iff (!rst_n)
        clk_en && gin_s2 == gin_s3
        |=> gpio_input_level == $past(gin_s3))
        else $error("settled input level not taken");
endmodule : mspcr_regs

// [tb/mspcr_pin_model.sv]
// external gpio lines as seen by the register bank
`timescale 1ns/1ns
module mspcr_pin_model (
    input wire logic [7:0] gpio_out,
    input wire logic [7:0] gpio_oe_n,
    input wire logic [7:0] ext_level,
    output logic [7:0] gpio_in
);
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            gpio_in[i] = gpio_oe_n[i] ? ext_level[i] : gpio_out[i];
        end
    end
endmodule : mspcr_pin_model

// [tb/test_mspcr_regs.sv]
// self-checking bench for the serial port config register bank
`timescale 1ns/1ns
module test_mspcr_regs;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic four_port = 1'b0;
    mspcr_pkg::mspcr_aux_req_s aux_req = '0;
    logic [11:0] uart_addr = 12'h000;
    logic [7:0] ext_level = 8'h3c;
    logic [7:0] aux_rdata;
    logic aux_rvalid;
    mspcr_pkg::mspcr_win_s uart_win;
    logic [7:0] gpio_in;
    logic [7:0] gpio_out;
    logic [7:0] gpio_oe_n;
    logic [31:0] port_iface;
    mspcr_pkg::mspcr_mode_e [7:0] port_mode;
    logic [3:0] codes [4] = '{4'h0, 4'h1, 4'hf, 4'hb};
    logic [3:0] onehot [4] = '{4'h1, 4'h2, 4'h4, 4'h8};
    int n_errors = 0;
    int total_checks = 0;
    always #2 ref_clk = ~ref_clk;
    mspcr_regs DUT (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .four_port(four_port),
        .aux_req(aux_req),
        .aux_rdata(aux_rdata),
        .aux_rvalid(aux_rvalid),
        .uart_addr(uart_addr),
        .uart_win(uart_win),
        .gpio_in(gpio_in),
        .gpio_out(gpio_out),
        .gpio_oe_n(gpio_oe_n),
        .port_iface(port_iface),
        .port_mode(port_mode)
    );
    mspcr_pin_model pins (
        .gpio_out(gpio_out),
        .gpio_oe_n(gpio_oe_n),
        .ext_level(ext_level),
        .gpio_in(gpio_in)
    );
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic report(input string what);
        n_errors++;
        $display("mismatch at %0t: %s", $time, what);
    endtask : report
    task automatic chk_byte(input logic [7:0] got, exp, input string what);
        total_checks++;
        if (got !== exp) report(what);
    endtask : chk_byte
    task automatic chk_word(input logic [31:0] got, exp, input string what);
        total_checks++;
        if (got !== exp) report(what);
    endtask : chk_word
    task automatic chk_win(input mspcr_pkg::mspcr_win_s got, exp);
        total_checks++;
        if (got !== exp) report("uart window decode");
    endtask : chk_win
    task automatic wr(input logic [3:0] addr, input logic [7:0] data);
        @(posedge ref_clk);
        aux_req <= '{rd: 1'b0, wr: 1'b1, addr: addr, wdata: data};
        @(posedge ref_clk);
        aux_req <= '0;
    endtask : wr
    // read is taken at the second edge; valid stands only in the next cycle
    task automatic rd_chk(input logic [3:0] addr, input logic [7:0] exp);
        @(posedge ref_clk);
        aux_req <= '{rd: 1'b1, wr: 1'b0, addr: addr, wdata: 8'h00};
        @(posedge ref_clk);
        aux_req <= '0;
        #1;
        chk_byte({7'h00, aux_rvalid}, 8'h01, "read valid");
        chk_byte(aux_rdata, exp, "read data");
    endtask : rd_chk
    task automatic win_chk(input logic [11:0] a, input logic fp,
                           input mspcr_pkg::mspcr_win_s exp);
        @(posedge ref_clk);
        four_port <= fp;
        uart_addr <= a;
        repeat (3) @(posedge ref_clk);
        #1;
        if (exp.hit) chk_win(uart_win, exp);
        else chk_byte({7'h00, uart_win.hit}, 8'h00, "window hit");
    endtask : win_chk
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : print_verdict
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        repeat (4000) @(posedge ref_clk);
        report("watchdog expired");
        print_verdict();
    end
    initial begin
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        #1;
        chk_word(port_mode, 32'h11111111, "reset modes");
        chk_byte(gpio_oe_n, 8'hff, "reset direction");
        for (int a = 0; a < 16; a++) begin
            if (a < 4 || a == 8 || a > 10) wr(4'(a), 8'hff);
        end
        repeat (6) @(posedge ref_clk);
        for (int a = 0; a < 16; a++) begin
            rd_chk(4'(a), (a == 8) ? 8'h3c : 8'h00);
        end
        $display("test aux map done");
        for (int k = 0; k < 4; k++) begin
            for (int a = 4; a < 8; a++) wr(4'(a), {codes[k], codes[k]});
            @(posedge ref_clk);
            #1;
            chk_word(port_iface, {8{codes[k]}}, "select");
            chk_word(port_mode, {8{onehot[k]}}, "mode");
            rd_chk(4'h6, {codes[k], codes[k]});
        end
        wr(4'h4, 8'h1b);
        @(posedge ref_clk);
        #1;
        chk_byte(port_iface[7:0], 8'h1b, "nibble order");
        chk_byte(port_mode[1:0], 8'h28, "nibble modes");
        $display("test line modes done");
        wr(4'h9, 8'h0f);
        wr(4'ha, 8'ha5);
        @(posedge ref_clk);
        clk_en <= 1'b0;
        wr(4'h9, 8'hff);
        clk_en <= 1'b1;
        @(posedge ref_clk);
        #1;
        chk_byte(gpio_oe_n, 8'hf0, "direction");
        chk_byte(gpio_out, 8'ha5, "termination");
        repeat (6) @(posedge ref_clk);
        rd_chk(4'h8, 8'h35);
        rd_chk(4'h9, 8'h0f);
        rd_chk(4'ha, 8'ha5);
        $display("test gpio done");
        win_chk(12'h000, 1'b0, {1'b1, 3'h0, 9'h000});
        win_chk(12'h400, 1'b0, {1'b1, 3'h2, 9'h000});
        win_chk(12'h3ff, 1'b0, {1'b1, 3'h1, 9'h1ff});
        win_chk(12'he05, 1'b0, {1'b1, 3'h7, 9'h005});
        win_chk(12'he05, 1'b1, {1'b1, 3'h3, 9'h005});
        win_chk(12'h5ff, 1'b1, {1'b1, 3'h2, 9'h1ff});
        win_chk(12'h600, 1'b1, {1'b0, 3'h0, 9'h000});
        $display("test uart decode done");
        wr(4'h5, 8'h1f);
        wr(4'h7, 8'h0b);
        wr(4'h6, 8'hff);
        @(posedge ref_clk);
        #1;
        chk_word(port_iface, 32'h0000bf1b, "alt layout");
        chk_byte({4'h0, port_mode[3]}, 8'h08, "alt mode");
        chk_word(32'(mspcr_pkg::REF_CLK_HZ / (mspcr_pkg::BAUD_OVERSAMPLE
                 * 32'h1c200)), 32'h00000008, "divisor");
        $display("test alt layout done");
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        chk_word(port_iface, 32'h00000000, "reset selects");
        chk_word(port_mode, 32'h11111111, "mid reset modes");
        chk_byte(gpio_oe_n, 8'hff, "mid reset direction");
        chk_byte(gpio_out, 8'h00, "reset termination");
        chk_byte({7'h00, uart_win.hit}, 8'h00, "reset window");
        chk_byte({7'h00, aux_rvalid}, 8'h00, "reset valid");
        @(posedge ref_clk);
        rst_n <= 1'b1;
        rd_chk(4'h7, 8'h00);
        repeat (6) @(posedge ref_clk);
        rd_chk(4'h8, 8'h3c);
        $display("test mid reset done");
        print_verdict();
    end
endmodule : test_mspcr_regs
